/* File: dv/adc_acquisition_sequencer_tb.sv */
`timescale 1ns/1ps
module adc_acquisition_sequencer_tb;
  import adc_seq_pkg::*;
  logic        clk = 0, rst_n = 0, wr = 0, rd = 0, trig = 0, sleep = 0, sampling, conv_run;
  logic [1:0]  addr = '0;
  logic [7:0]  wdata = '0, rdata, d;
  logic [11:0] sar_val = '0, sar_result;
  int          fails = 0, cmp_count = 0;
  int          divs[8] = '{2, 8, 32, 2 * RC_HALF_DIV, 4, 16, 64, 2 * RC_HALF_DIV};
  int          acqs[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  adc_acquisition_sequencer dut (.CLK_SYS(clk), .RSTN(rst_n), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .TRIG_EVENT(trig), .SLEEP(sleep),
    .SAR_RESULT(sar_result), .SAMPLING(sampling), .CONV_RUN(conv_run));
  sar_model u_sar (.code(sar_val), .result(sar_result));
  initial forever #2 clk = ~clk;
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task wr_reg(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk); addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  endtask : wr_reg
  task rd_reg(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    @(negedge clk); v = rdata;
  endtask : rd_reg
  task conv(input logic [7:0] cfg, input logic [11:0] v, input logic tg, input int lo,
            input int per);
    int pre, run;
    logic [15:0] e;
    pre = 0; run = 0; sar_val <= v;
    wr_reg(ADDR_ACQ_CLK, cfg); wr_reg(ADDR_CTRL0, 8'h01);
    if (tg) begin
      @(posedge clk); trig <= 1'b1;
      @(posedge clk); trig <= 1'b0;
    end else wr_reg(ADDR_CTRL0, 8'h03);
    @(negedge clk);
    while (!conv_run && pre < 2000) begin @(negedge clk); pre++; end
    while (conv_run && run < 9000) begin @(negedge clk); run++; end
    chk("acq cycles", 16'h1, 16'(pre >= lo && pre <= lo + 6));
    chk("conv cycles", 16'h1, 16'(run >= 13 * per && run <= 13 * per + 2));
    repeat (2) @(negedge clk);
    rd_reg(ADDR_CTRL0, d); chk("ctrl0", 16'h05, 16'(d));
    e = cfg[JUSTIFY_BIT] ? {4'h0, v} : {v, 4'h0};
    rd_reg(ADDR_RES_HIGH, d); chk("res high", 16'(e[15:8]), 16'(d));
    rd_reg(ADDR_RES_LOW, d); chk("res low", 16'(e[7:0]), 16'(d));
    chk("sampling", 16'h1, 16'(sampling));
    wr_reg(ADDR_CTRL0, 8'h01);
    $display("conversion with config %h done", cfg);
  endtask : conv
  task t_reset;
    rd_reg(ADDR_ACQ_CLK, d); chk("acq clk reset", 16'h00, 16'(d));
    rd_reg(ADDR_CTRL0, d); chk("ctrl0 reset", 16'h00, 16'(d));
    wr_reg(ADDR_ACQ_CLK, 8'hFF); rd_reg(ADDR_ACQ_CLK, d);
    chk("acq clk mask", 16'hBF, 16'(d));
    $display("reset and mask test done");
  endtask : t_reset
  task t_codes;
    int lo;
    for (int i = 0; i < 8; i++) begin
      conv({i[0], 4'(i[2:0]), 3'h0}, 12'hA5C ^ 12'(i), 1'b0, acqs[i] * 2, 2);
    end
    for (int i = 0; i < 8; i++) begin
      lo = (i[1:0] == 2'b11) ? INSTR_CYCLES : 0;
      conv({5'h10, 3'(i)}, 12'h3C9, 1'b0, lo, divs[i]);
    end
    $display("code tables test done");
  endtask : t_codes
  task t_trig;
    wr_reg(ADDR_CTRL0, 8'h00);
    @(posedge clk); trig <= 1'b1;
    @(posedge clk); trig <= 1'b0;
    repeat (20) @(posedge clk);
    rd_reg(ADDR_CTRL0, d); chk("trig off", 16'h00, 16'(d));
    conv(8'h80, 12'h5A1, 1'b1, 0, 2);
    $display("trigger test done");
  endtask : t_trig
  task t_sleep;
    int n;
    n = 0; sleep <= 1'b1;
    wr_reg(ADDR_ACQ_CLK, 8'h80); wr_reg(ADDR_CTRL0, 8'h03);
    repeat (60) @(posedge clk);
    rd_reg(ADDR_CTRL0, d); chk("frozen in sleep", 16'h03, 16'(d));
    @(posedge clk); sleep <= 1'b0;
    while (conv_run && n < 100) begin @(negedge clk); n++; end
    repeat (2) @(negedge clk);
    rd_reg(ADDR_CTRL0, d); chk("woken", 16'h05, 16'(d));
    @(posedge clk); sleep <= 1'b1;
    conv(8'h83, 12'h7E2, 1'b0, INSTR_CYCLES, 2 * RC_HALF_DIV);
    sleep <= 1'b0;
    $display("sleep test done");
  endtask : t_sleep
  task t_abort;
    wr_reg(ADDR_ACQ_CLK, 8'h80); wr_reg(ADDR_CTRL0, 8'h01); wr_reg(ADDR_CTRL0, 8'h03);
    repeat (5) @(negedge clk);
    chk("busy before reset", 16'h1, 16'(conv_run));
    @(posedge clk); rst_n <= 1'b0;
    @(negedge clk); chk("outputs in reset", 16'h0, 16'({sampling, conv_run}));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(ADDR_CTRL0, d); chk("ctrl0 after abort", 16'h00, 16'(d));
    rd_reg(ADDR_ACQ_CLK, d); chk("acq clk after abort", 16'h00, 16'(d));
    $display("abort test done");
  endtask : t_abort
  task close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset; t_codes; t_trig; t_sleep; t_abort;
    close_out;
  end
  initial begin
    #200000;
    fails++;
    close_out;
  end
endmodule : adc_acquisition_sequencer_tb

/* File: dv/adc_seq_properties.sv */
`timescale 1ns/1ps
module adc_seq_properties
  import adc_seq_pkg::*;
#(
  parameter int RESULT_W = 12
) (
  input wire logic        CLK_SYS,
  input wire logic        RSTN,
  input wire logic [1:0]  ADDR,
  input wire logic [7:0]  WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [7:0]  RDATA,
  input wire logic        TRIG_EVENT,
  input wire logic        SLEEP,
  input wire logic [11:0] SAR_RESULT,
  input wire logic        SAMPLING,
  input wire logic        CONV_RUN
);
  logic       en_r;
  logic [7:0] cfg_r;
  logic       go_wr;
  assign go_wr = WR && ADDR == ADDR_CTRL0 && WDATA[1:0] == 2'b11 && SAMPLING;
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) en_r <= 1'b0;
    else if (WR && ADDR == ADDR_CTRL0) en_r <= WDATA[0];
  end
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) cfg_r <= 8'h00;
    else if (WR && ADDR == ADDR_ACQ_CLK) cfg_r <= WDATA;
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  property p_reset; disable iff (1'b0) !RSTN |=> !CONV_RUN && !SAMPLING; endproperty
  a_reset: assert property (p_reset) else $error("converter active after reset");
  property p_excl; !(SAMPLING && CONV_RUN); endproperty
  a_excl: assert property (p_excl) else $error("sampling while converting");
  property p_resume; $fell(CONV_RUN) && en_r |-> ##[0:2] SAMPLING; endproperty
  a_resume: assert property (p_resume) else $error("sampling did not resume");
  property p_bit6; $past(RD) && $past(ADDR) == ADDR_ACQ_CLK |-> !RDATA[6]; endproperty
  a_bit6: assert property (p_bit6) else $error("bit six read as one");
  property p_just;
    $past(RD) && $past(ADDR) == ADDR_RES_HIGH && cfg_r[JUSTIFY_BIT] |-> RDATA[7:4] == 4'h0;
  endproperty
  a_just: assert property (p_just) else $error("upper result bits not zero");
  property p_manual; go_wr && cfg_r[5:3] == 3'h0 && cfg_r[1:0] != 2'b11 |-> ##[1:3] CONV_RUN;
  endproperty
  a_manual: assert property (p_manual) else $error("manual go did not convert");
  property p_acq; go_wr && cfg_r[5:3] != 3'h0 |=> (!CONV_RUN)[*3]; endproperty
  a_acq: assert property (p_acq) else $error("acquisition skipped");
  property p_rc; go_wr && cfg_r[1:0] == 2'b11 |=> (!CONV_RUN)[*8]; endproperty
  a_rc: assert property (p_rc) else $error("rc start delay missing");
  property p_len; $rose(CONV_RUN) |-> CONV_RUN[*8]; endproperty
  a_len: assert property (p_len) else $error("conversion too short");
  property p_trig_off; !en_r && TRIG_EVENT |=> (!CONV_RUN)[*8]; endproperty
  a_trig_off: assert property (p_trig_off) else $error("trigger taken while off");
  property p_status; $past(RD) && $past(ADDR) == ADDR_CTRL0 |-> RDATA[7:3] == 5'h00; endproperty
  a_status: assert property (p_status) else $error("phase status visible");
  property p_just_left;
    $past(RD) && $past(ADDR) == ADDR_RES_LOW && !cfg_r[JUSTIFY_BIT] |-> RDATA[3:0] == 4'h0;
  endproperty
  a_just_left: assert property (p_just_left) else $error("lower result bits not zero");
endmodule : adc_seq_properties
bind adc_acquisition_sequencer adc_seq_properties #(.RESULT_W(RESULT_W)) u_props (.CLK_SYS,
  .RSTN, .ADDR, .WDATA, .WR, .RD, .RDATA, .TRIG_EVENT, .SLEEP, .SAR_RESULT, .SAMPLING, .CONV_RUN);

/* File: dv/sar_model.sv */
`timescale 1ns/1ps
// ********************
// Settled front end
// ********************
module sar_model (
  input  wire logic [11:0] code,
  output logic      [11:0] result
);
  // Holding the code from go to completion stands for a settled input.
  assign result = code;
endmodule : sar_model

/* File: hw/adc_acquisition_sequencer.sv */
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module adc_acquisition_sequencer
  import adc_seq_pkg::*;
#(
  parameter int RESULT_W = 12
) (
  input  wire logic       CLK_SYS,
  input  wire logic       RSTN,
  input  wire logic [1:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic       TRIG_EVENT,
  input  wire logic       SLEEP,
  input  wire logic [11:0] SAR_RESULT,
  output logic            SAMPLING,
  output logic            CONV_RUN
);

  // The result pair packing below is written for exactly twelve result bits.
  if (RESULT_W != 12) begin : g_bad_result_w
    $error("Result width must be 12.");
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic       enable_r;
  logic       go_r;
  logic       done_flag_r;
  logic [7:0] acq_clk_r;
  logic [7:0] res_high_r;
  logic [7:0] res_low_r;
  logic [7:0] rdata_r;
  seq_state_t state_r;
  logic [4:0] period_cnt_r;
  logic [5:0] rc_wait_r;
  logic       sampling_r;
  logic       conv_run_r;
  logic       start;
  logic       finish;
  logic       is_rc;
  logic       clk_ok;
  logic [2:0] acq_code;

  tick_if tk ();

  adc_bit_clock u_bit_clock (
    .clk   (CLK_SYS),
    .rst_n (RSTN),
    .tk    (tk)
  );

  assign is_rc    = acq_clk_r[CLK_LSB+1] & acq_clk_r[CLK_LSB];
  assign acq_code = acq_clk_r[ACQ_LSB+2:ACQ_LSB];
  // The oscillator divider keeps counting in sleep but its ticks are ignored; only RC source ticks advance the sequence.
  assign clk_ok = is_rc | ~SLEEP; // RULE5
  assign tk.ratio   = clk_div(acq_clk_r[CLK_LSB+2:CLK_LSB]); // RULE3
  assign tk.restart = (state_r == ST_SAMPLE) | (state_r == ST_RC_WAIT);

  wire wr_ctrl0 = WR && (ADDR == ADDR_CTRL0);
  assign start  = enable_r && !go_r &&
                  ((wr_ctrl0 && WDATA[CTRL0_GO_BIT]) || TRIG_EVENT); // RULE16 RULE17 RULE18
  assign finish = (state_r == ST_FINISH);

  // ****************************************************************
  // Control registers
  // ****************************************************************
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      enable_r  <= 1'b0; // RULE6
      acq_clk_r <= ACQ_CLK_RESET; // RULE11
    end else begin
      if (wr_ctrl0) enable_r <= WDATA[CTRL0_ENABLE_BIT];
      if (WR && ADDR == ADDR_ACQ_CLK) acq_clk_r <= WDATA & ACQ_CLK_MASK; // RULE15
    end
  end

  // Go is held by hardware; software can clear it mid-conversion only by clearing enable.
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      go_r <= 1'b0;
    end else if (finish || !enable_r) begin
      go_r <= 1'b0; // RULE7
    end else if (start) begin
      go_r <= 1'b1; // RULE18
    end
  end

  // Set wins over a clear in the same cycle.
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      done_flag_r <= 1'b0;
    end else if (finish) begin
      done_flag_r <= 1'b1; // RULE7
    end else if (wr_ctrl0 && !WDATA[CTRL0_DONE_BIT]) begin
      done_flag_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      state_r      <= ST_SAMPLE;
      period_cnt_r <= '0;
      rc_wait_r    <= '0;
    end else if (!enable_r) begin
      state_r <= ST_SAMPLE; // RULE6
    end else begin
      unique case (state_r)
        ST_SAMPLE: begin
          period_cnt_r <= '0;
          rc_wait_r    <= '0;
          if (start) begin
            if (is_rc) state_r <= ST_RC_WAIT; // RULE4
            else if (acq_code == 3'h0) state_r <= ST_CONVERT; // RULE9
            else state_r <= ST_ACQUIRE; // RULE8
          end
        end
        ST_RC_WAIT: begin
          rc_wait_r <= rc_wait_r + 6'd1;
          if (rc_wait_r == 6'(INSTR_CYCLES - 1)) begin // RULE4
            if (acq_code == 3'h0) state_r <= ST_CONVERT; // RULE9
            else state_r <= ST_ACQUIRE; // RULE8
          end
        end
        ST_ACQUIRE: begin
          if (tk.tick && clk_ok) begin
            if (period_cnt_r == acq_periods(acq_code) - 5'd1) begin // RULE2 RULE8
              period_cnt_r <= '0;
              state_r      <= ST_CONVERT;
            end else begin
              period_cnt_r <= period_cnt_r + 5'd1;
            end
          end
        end
        ST_CONVERT: begin
          if (tk.tick && clk_ok) begin
            if (period_cnt_r == 5'(CONV_BIT_PERIODS - 1)) state_r <= ST_FINISH; // RULE14
            else period_cnt_r <= period_cnt_r + 5'd1;
          end
        end
        ST_FINISH: state_r <= ST_SAMPLE; // RULE12
      endcase
    end
  end

  // ****************************************************************
  // Result pair
  // ****************************************************************
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      res_high_r <= '0;
      res_low_r  <= '0;
    end else if (finish) begin // RULE7
      if (acq_clk_r[JUSTIFY_BIT]) begin // RULE1
        res_high_r <= {4'h0, SAR_RESULT[11:8]}; // RULE19
        res_low_r  <= SAR_RESULT[7:0];
      end else begin
        res_high_r <= SAR_RESULT[11:4];
        res_low_r  <= {SAR_RESULT[3:0], 4'h0}; // RULE19
      end
    end
  end

  // Only enable, go and done are visible; the phase is deliberately hidden.
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      rdata_r <= '0;
    end else if (RD) begin
      unique case (ADDR)
        ADDR_CTRL0:    rdata_r <= {5'h00, done_flag_r, go_r, enable_r}; // RULE13
        ADDR_ACQ_CLK:  rdata_r <= acq_clk_r & ACQ_CLK_MASK; // RULE15
        ADDR_RES_HIGH: rdata_r <= res_high_r;
        ADDR_RES_LOW:  rdata_r <= res_low_r;
      endcase
    end else begin
      rdata_r <= '0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      sampling_r <= 1'b0;
      conv_run_r <= 1'b0;
    end else begin
      sampling_r <= enable_r && (state_r != ST_CONVERT) && (state_r != ST_FINISH); // RULE12
      conv_run_r <= enable_r && (state_r == ST_CONVERT);
    end
  end

  assign RDATA    = rdata_r;
  assign SAMPLING = sampling_r;
  assign CONV_RUN = conv_run_r;

endmodule : adc_acquisition_sequencer

/* File: hw/adc_bit_clock.sv */
`timescale 1ns/1ps
module adc_bit_clock
  import adc_seq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  tick_if.src      tk
);

  logic [DIV_W-1:0] cnt_r;
  logic             tick_r;

  assign tk.tick = tick_r;

  // Restarting clears the phase so each conversion begins on a full period.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else if (tk.restart) begin // RULE20
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else if (cnt_r >= tk.ratio - 10'd1) begin // RULE20
      cnt_r  <= '0;
      tick_r <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + 10'd1;
      tick_r <= 1'b0;
    end
  end

endmodule : adc_bit_clock

/* File: hw/adc_seq_pkg.sv */
// Behaviour
// (RULE1) Justify bit set selects right justification.
// (RULE2) Acquisition code maps to 0..20 bit periods.
// (RULE3) Clock code selects divider or RC source.
// (RULE4) RC source adds one instruction cycle delay.
// (RULE5) Conversion continues in sleep only on RC.
// (RULE6) Reset clears registers and aborts conversion.
// (RULE7) Completion loads result, clears go, flags.
// (RULE8) Nonzero code samples, then converts automatically.
// (RULE9) Code zero converts at once on go.
// (RULE10) Software times manual acquisition itself.
// (RULE11) Acquisition field resets to manual code.
// (RULE12) Sampling resumes after every conversion.
// (RULE13) No acquisition or conversion phase status shown.
// (RULE14) Conversion lasts thirteen bit periods.
// (RULE15) Bit six reads zero, ignores writes.
// (RULE16) Enabled trigger sets go and starts.
// (RULE17) Trigger ignored while converter disabled.
// (RULE18) Software go starts sequence while enabled.
// (RULE19) Unused result bits read zero.
// (RULE20) Divider derives bit periods, restarts per conversion.
package adc_seq_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [1:0] ADDR_CTRL0      = 2'h0;
  localparam logic [1:0] ADDR_ACQ_CLK    = 2'h1;
  localparam logic [1:0] ADDR_RES_HIGH   = 2'h2;
  localparam logic [1:0] ADDR_RES_LOW    = 2'h3;

  localparam int CTRL0_ENABLE_BIT = 0;
  localparam int CTRL0_GO_BIT     = 1;
  localparam int CTRL0_DONE_BIT   = 2;
  localparam int JUSTIFY_BIT      = 7;
  localparam int ACQ_LSB          = 3;
  localparam int CLK_LSB          = 0;

  localparam logic [7:0] ACQ_CLK_RESET = 8'h00;
  localparam logic [7:0] ACQ_CLK_MASK  = 8'hBF;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CONV_BIT_PERIODS = 13;
  localparam int INSTR_CYCLE_NS   = 160;
  localparam int CLK_PERIOD_NS    = 4;
  localparam int INSTR_CYCLES     = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RC_HALF_DIV      = 313;
  localparam int DIV_W            = 10;

  typedef enum logic [2:0] {ST_SAMPLE, ST_RC_WAIT, ST_ACQUIRE, ST_CONVERT, ST_FINISH} seq_state_t;

  function automatic logic [4:0] acq_periods(input logic [2:0] code);
    unique case (code)
      3'h0: acq_periods = 5'd0;
      3'h1: acq_periods = 5'd2;
      3'h2: acq_periods = 5'd4;
      3'h3: acq_periods = 5'd6;
      3'h4: acq_periods = 5'd8;
      3'h5: acq_periods = 5'd12;
      3'h6: acq_periods = 5'd16;
      3'h7: acq_periods = 5'd20;
    endcase
  endfunction : acq_periods

  function automatic logic [DIV_W-1:0] clk_div(input logic [2:0] code);
    unique case (code)
      3'h0: clk_div = 10'd2;
      3'h1: clk_div = 10'd8;
      3'h2: clk_div = 10'd32;
      3'h4: clk_div = 10'd4;
      3'h5: clk_div = 10'd16;
      3'h6: clk_div = 10'd64;
      default: clk_div = 10'(2 * RC_HALF_DIV);
    endcase
  endfunction : clk_div

endpackage : adc_seq_pkg

/* File: hw/tick_if.sv */
`timescale 1ns/1ps
interface tick_if;
  import adc_seq_pkg::*;
  logic             restart;
  logic [DIV_W-1:0] ratio;
  logic             tick;
  modport src (input restart, input ratio, output tick);
  modport dst (output restart, output ratio, input tick);
endinterface : tick_if
